/* rtl/uart_byte_fifo.sv */
`timescale 1ns/1ps
module uart_byte_fifo (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  output logic [4:0] count
);
  logic [7:0] mem [uart_regs_pkg::FIFO_DEPTH];
  logic [3:0] wp;
  logic [3:0] rp;
  logic push;
  logic pop;
  assign in_ready = count != uart_regs_pkg::FIFO_FULL;
  assign out_valid = count != 5'h00;
  assign out_data = mem[rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp <= 4'h0;
      rp <= 4'h0;
      count <= 5'h00;
    end else if (clear) begin
      wp <= 4'h0;
      rp <= 4'h0;
      count <= 5'h00;
    end else begin
      wp <= wp + 4'(push);
      rp <= rp + 4'(pop);
      count <= count + 5'(push) - 5'(pop);
    end
  end
  property p_full_refuses;
    @(posedge clk) disable iff (reset) !in_ready |-> count == uart_regs_pkg::FIFO_FULL;
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("fifo refused while not full");
endmodule

/* rtl/uart_host_regmap.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module uart_host_regmap (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Transmit stream to the serial engine
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TX_SHIFT_IDLE,
  // Receive stream from the serial engine
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic CHAR_TICK,
  // Line and modem events
  input wire uart_regs_pkg::line_err_t LINE_ERR,
  input wire uart_regs_pkg::modem_delta_t MODEM_DELTA,
  input wire logic [3:0] MODEM_LINES,
  // Configuration and interrupt
  output logic [15:0] BAUD_DIVISOR,
  output logic [6:0] LINE_SETUP,
  output logic HOST_IRQ_OUT
);
  logic [5:0] idx;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic divisor_access_select;
  logic [7:0] line_ctrl;
  logic [3:0] interrupt_enable_mask;
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic [7:0] scratch;
  logic fifo_en;
  logic [1:0] rx_trig;
  logic tx_rst;
  logic rx_rst;
  logic [3:0] line_err;
  logic line_pend;
  logic [3:0] modem_delta;
  logic [3:0] irq_status;
  logic [3:0] src;
  logic [3:0] iir_code;
  logic [31:0] next_rdata;
  logic tx_push;
  logic tx_in_ready;
  logic tx_pop;
  logic [4:0] tx_count;
  logic rx_pop;
  logic rx_in_ready;
  logic rx_ready_flag;
  logic [7:0] rx_head;
  logic [4:0] rx_count;
  logic rx_drop;
  logic rx_avail;
  logic tmo;
  logic tx_holding_empty_flag;
  logic [7:0] line_state;
  logic [7:0] modem_line_state;

  function automatic logic is_mapped(input logic [5:0] a);
    case (a)
      uart_regs_pkg::IDX_DATA, uart_regs_pkg::IDX_IER, uart_regs_pkg::IDX_FCR,
      uart_regs_pkg::IDX_LCR, uart_regs_pkg::IDX_LSR, uart_regs_pkg::IDX_MSR,
      uart_regs_pkg::IDX_SCR, uart_regs_pkg::IDX_IST: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Zero wait states: every access completes in its first access cycle
  assign idx = PADDR[7:2];
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign mapped = is_mapped(idx);
  assign wr = access & PWRITE & mapped;
  assign rd = access & ~PWRITE & mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign divisor_access_select = line_ctrl[uart_regs_pkg::LCR_DIV];

  assign tx_push = wr & idx == uart_regs_pkg::IDX_DATA & ~divisor_access_select;
  assign rx_pop = rd & idx == uart_regs_pkg::IDX_DATA & ~divisor_access_select;
  assign tx_pop = TX_VALID & TX_READY;

  uart_byte_fifo tx_fifo (
    .clk(CLK),
    .reset(RESET),
    .clear(tx_rst),
    .in_valid(tx_push),
    .in_data(PWDATA[7:0]),
    .in_ready(tx_in_ready),
    .out_valid(TX_VALID),
    .out_data(TX_DATA),
    .out_ready(TX_READY),
    .count(tx_count)
  );

  uart_byte_fifo rx_fifo (
    .clk(CLK),
    .reset(RESET),
    .clear(rx_rst),
    .in_valid(RX_VALID),
    .in_data(RX_DATA),
    .in_ready(rx_in_ready),
    .out_valid(rx_ready_flag),
    .out_data(rx_head),
    .out_ready(rx_pop),
    .count(rx_count)
  );

  uart_rx_timeout rx_timer (
    .clk(CLK),
    .reset(RESET),
    .enable(fifo_en),
    .has_data(rx_ready_flag),
    .activity(rx_pop | (RX_VALID & rx_in_ready)),
    .char_tick(CHAR_TICK),
    .timeout(tmo)
  );

  assign rx_drop = RX_VALID & ~rx_in_ready;

  // Divisor latch and line control
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      baud_divisor_low <= uart_regs_pkg::BYTE_RST;
      baud_divisor_high <= uart_regs_pkg::BYTE_RST;
      line_ctrl <= uart_regs_pkg::BYTE_RST;
      scratch <= uart_regs_pkg::BYTE_RST;
    end else if (wr) begin
      if (idx == uart_regs_pkg::IDX_DATA && divisor_access_select) begin
        baud_divisor_low <= PWDATA[7:0];
      end
      if (idx == uart_regs_pkg::IDX_IER && divisor_access_select) begin
        baud_divisor_high <= PWDATA[7:0];
      end
      if (idx == uart_regs_pkg::IDX_LCR) begin
        line_ctrl <= PWDATA[7:0];
      end
      if (idx == uart_regs_pkg::IDX_SCR) begin
        scratch <= PWDATA[7:0];
      end
    end
  end
  assign BAUD_DIVISOR = {baud_divisor_high, baud_divisor_low};
  assign LINE_SETUP = line_ctrl[6:0];

  // Interrupt enables
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      interrupt_enable_mask <= uart_regs_pkg::IER_RST;
    end else if (wr && idx == uart_regs_pkg::IDX_IER && !divisor_access_select) begin
      interrupt_enable_mask <= PWDATA[3:0];
    end
  end

  // FIFO setup; the reset bits are one-cycle pulses, and toggling enable empties both FIFOs
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      fifo_en <= 1'b0;
      rx_trig <= uart_regs_pkg::TRIG_RST;
      tx_rst <= 1'b0;
      rx_rst <= 1'b0;
    end else if (wr && idx == uart_regs_pkg::IDX_FCR) begin
      fifo_en <= PWDATA[uart_regs_pkg::FCR_EN];
      rx_trig <= PWDATA[uart_regs_pkg::FCR_TRIG+:2];
      tx_rst <= PWDATA[uart_regs_pkg::FCR_TXRST] | (PWDATA[uart_regs_pkg::FCR_EN] != fifo_en);
      rx_rst <= PWDATA[uart_regs_pkg::FCR_RXRST] | (PWDATA[uart_regs_pkg::FCR_EN] != fifo_en);
    end else begin
      tx_rst <= 1'b0;
      rx_rst <= 1'b0;
    end
  end

  // Line errors stick until line status is read; a new error wins over the read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      line_err <= 4'h0;
      line_pend <= 1'b0;
    end else begin
      if (rd && idx == uart_regs_pkg::IDX_LSR) begin
        line_err <= LINE_ERR | {3'h0, rx_drop};
        line_pend <= |(LINE_ERR | {3'h0, rx_drop});
      end else begin
        line_err <= line_err | LINE_ERR | {3'h0, rx_drop};
        line_pend <= line_pend | (|((LINE_ERR | {3'h0, rx_drop}) & ~line_err));
      end
    end
  end

  // Modem deltas stick until modem status is read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      modem_delta <= 4'h0;
    end else if (rd && idx == uart_regs_pkg::IDX_MSR) begin
      modem_delta <= MODEM_DELTA;
    end else begin
      modem_delta <= modem_delta | MODEM_DELTA;
    end
  end

  assign tx_holding_empty_flag = tx_count == 5'h00;
  assign line_state = {fifo_en & (|line_err), tx_holding_empty_flag & TX_SHIFT_IDLE,
                       tx_holding_empty_flag, line_err, rx_ready_flag};
  assign modem_line_state = {MODEM_LINES, modem_delta};
  assign rx_avail = fifo_en ? rx_count >= uart_regs_pkg::trig_level(rx_trig) : rx_ready_flag;

  // Raw sources in enable-bit layout
  assign src[uart_regs_pkg::IE_RX] = rx_avail | (fifo_en & tmo);
  assign src[uart_regs_pkg::IE_TX] = tx_holding_empty_flag;
  assign src[uart_regs_pkg::IE_LS] = line_pend;
  assign src[uart_regs_pkg::IE_MS] = |modem_delta;

  // Sticky event status, write one to clear; a live source wins over the clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_status <= 4'h0;
    end else if (wr && idx == uart_regs_pkg::IDX_IST) begin
      irq_status <= (irq_status & ~PWDATA[3:0]) | src;
    end else begin
      irq_status <= irq_status | src;
    end
  end
  assign HOST_IRQ_OUT = |(irq_status & interrupt_enable_mask);

  // Identifier code, only enabled live sources count
  always_comb begin
    iir_code = uart_regs_pkg::IIR_NONE;
    if (interrupt_enable_mask[uart_regs_pkg::IE_LS] && src[uart_regs_pkg::IE_LS]) begin
      iir_code = uart_regs_pkg::IIR_LS;
    end else if (interrupt_enable_mask[uart_regs_pkg::IE_RX] && rx_avail) begin
      iir_code = uart_regs_pkg::IIR_RX;
    end else if (interrupt_enable_mask[uart_regs_pkg::IE_RX] && fifo_en && tmo) begin
      iir_code = uart_regs_pkg::IIR_TMO;
    end else if (interrupt_enable_mask[uart_regs_pkg::IE_TX] && src[uart_regs_pkg::IE_TX]) begin
      iir_code = uart_regs_pkg::IIR_TX;
    end else if (interrupt_enable_mask[uart_regs_pkg::IE_MS] && src[uart_regs_pkg::IE_MS]) begin
      iir_code = uart_regs_pkg::IIR_MS;
    end
  end

  // Read data is captured in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
      uart_regs_pkg::IDX_DATA: begin
        next_rdata[7:0] = divisor_access_select ? baud_divisor_low : rx_head;
      end
      uart_regs_pkg::IDX_IER: begin
        next_rdata[7:0] = divisor_access_select ? baud_divisor_high : {4'h0, interrupt_enable_mask};
      end
      uart_regs_pkg::IDX_FCR: next_rdata[7:0] = {{2{fifo_en}}, 2'h0, iir_code};
      uart_regs_pkg::IDX_LCR: next_rdata[7:0] = line_ctrl;
      uart_regs_pkg::IDX_LSR: next_rdata[7:0] = line_state;
      uart_regs_pkg::IDX_MSR: next_rdata[7:0] = modem_line_state;
      uart_regs_pkg::IDX_SCR: next_rdata[7:0] = scratch;
      uart_regs_pkg::IDX_IST: next_rdata[3:0] = irq_status;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= next_rdata;
    end
  end

  property p_tx_push;
    @(posedge CLK) disable iff (RESET) tx_push && tx_in_ready && !tx_pop && !tx_rst |=> tx_count == $past(tx_count) + 5'h01;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("data write did not fill transmit fifo");
  property p_div_low;
    @(posedge CLK) disable iff (RESET)
      wr && idx == uart_regs_pkg::IDX_DATA && divisor_access_select |=> BAUD_DIVISOR[7:0] == $past(PWDATA[7:0]);
  endproperty
  a_div_low: assert property (p_div_low) else $error("divisor low not written");
  property p_ier_write;
    @(posedge CLK) disable iff (RESET)
      wr && idx == uart_regs_pkg::IDX_IER && !divisor_access_select |=> interrupt_enable_mask == $past(PWDATA[3:0]);
  endproperty
  a_ier_write: assert property (p_ier_write) else $error("enable register not written");
  property p_ier_high_zero;
    @(posedge CLK) disable iff (RESET)
      setup && !PWRITE && idx == uart_regs_pkg::IDX_IER && !divisor_access_select |=> PRDATA[31:4] == 28'h0;
  endproperty
  a_ier_high_zero: assert property (p_ier_high_zero) else $error("enable upper bits not zero");
  property p_fifo_reset;
    @(posedge CLK) disable iff (RESET) tx_rst |=> !tx_rst && tx_count == 5'h00;
  endproperty
  a_fifo_reset: assert property (p_fifo_reset) else $error("transmit fifo reset failed");
  property p_all_off;
    @(posedge CLK) disable iff (RESET) interrupt_enable_mask == 4'h0 |-> !HOST_IRQ_OUT && iir_code == uart_regs_pkg::IIR_NONE;
  endproperty
  a_all_off: assert property (p_all_off) else $error("interrupt with all sources disabled");
  // The enable must still stand when the sticky status has caught the source
  sequence s_thre_held;
    tx_holding_empty_flag && interrupt_enable_mask[1] ##1 interrupt_enable_mask[1];
  endsequence
  property p_thre_irq;
    @(posedge CLK) disable iff (RESET) s_thre_held |-> HOST_IRQ_OUT;
  endproperty
  a_thre_irq: assert property (p_thre_irq) else $error("transmit empty did not interrupt");
  sequence s_delta_held;
    MODEM_DELTA != 4'h0 && interrupt_enable_mask[3] ##1 interrupt_enable_mask[3] ##1 interrupt_enable_mask[3];
  endsequence
  property p_modem_irq;
    @(posedge CLK) disable iff (RESET) s_delta_held |-> HOST_IRQ_OUT;
  endproperty
  a_modem_irq: assert property (p_modem_irq) else $error("modem delta did not interrupt");
  sequence s_trig_held;
    fifo_en && rx_count >= uart_regs_pkg::trig_level(rx_trig) && interrupt_enable_mask[0] ##1 interrupt_enable_mask[0];
  endsequence
  property p_trig_irq;
    @(posedge CLK) disable iff (RESET) s_trig_held |-> HOST_IRQ_OUT;
  endproperty
  a_trig_irq: assert property (p_trig_irq) else $error("trigger level did not interrupt");
  property p_err_sticks;
    @(posedge CLK) disable iff (RESET) LINE_ERR.overrun |=> line_err[0] && line_pend;
  endproperty
  a_err_sticks: assert property (p_err_sticks) else $error("overrun not recorded");
endmodule

/* rtl/uart_regs_pkg.sv */
// Operation
// - Data address writes feed transmit FIFO and reads return received byte when divisor hidden.
// - Divisor access set maps addresses 0 and 1 to divisor low and high.
// - Divisor access clear maps address 1 to the interrupt enable register.
// - FIFO setup: trigger 7:6, reserved 5:4, zero 3, TX reset, RX reset, enable.
// - Interrupt enable bits 7 to 4 always read zero.
// - Each enable bit turns its own source on with 1, off with 0.
// - Disabled sources set no identifier code and never raise the host interrupt.
// - Line and modem status keep updating whatever the enables hold.
// - All enabled sources share one host interrupt output, each able to raise it.
// - Enable bit 3 lets any modem delta bit raise the host interrupt.
// - Enable bit 2 lets a change of overrun, parity, framing or break raise it.
// - Enable bit 1 lets transmit holding empty raise the host interrupt.
// - Enable bit 0 lets receive ready or FIFO character timeout raise it.
// - Trigger codes 00, 01, 10, 11 select 1, 4, 8, 14 bytes.
// - A FIFO reset bit empties its FIFO and then clears itself.
// - In FIFO mode receive-available code stands while count reaches the trigger.
// - Timeout when data waits and no receive or read for over four characters.
package uart_regs_pkg;
  localparam logic [5:0] IDX_DATA = 6'h00;
  localparam logic [5:0] IDX_IER = 6'h01;
  localparam logic [5:0] IDX_FCR = 6'h02;
  localparam logic [5:0] IDX_LCR = 6'h03;
  localparam logic [5:0] IDX_LSR = 6'h05;
  localparam logic [5:0] IDX_MSR = 6'h06;
  localparam logic [5:0] IDX_SCR = 6'h07;
  localparam logic [5:0] IDX_IST = 6'h08;
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_TRIG = 6;
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;
  localparam int LCR_DIV = 7;
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LS = 4'h6;
  localparam logic [3:0] IIR_RX = 4'h4;
  localparam logic [3:0] IIR_TMO = 4'hc;
  localparam logic [3:0] IIR_TX = 4'h2;
  localparam logic [3:0] IIR_MS = 4'h0;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
  typedef struct packed {logic brk; logic framing; logic parity; logic overrun;} line_err_t;
  typedef struct packed {logic dcd; logic teri; logic dsr; logic cts;} modem_delta_t;
  typedef enum logic [2:0] {TO_IDLE = 3'b001, TO_COUNT = 3'b010, TO_FIRED = 3'b100} tmo_state_t;
  function automatic logic [4:0] trig_level(input logic [1:0] code);
    case (code)
      2'h0: trig_level = TRIG_L0;
      2'h1: trig_level = TRIG_L1;
      2'h2: trig_level = TRIG_L2;
      default: trig_level = TRIG_L3;
    endcase
  endfunction
endpackage

/* rtl/uart_rx_timeout.sv */
`timescale 1ns/1ps
module uart_rx_timeout (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Receive activity
  input wire logic enable,
  input wire logic has_data,
  input wire logic activity,
  input wire logic char_tick,
  output logic timeout
);
  uart_regs_pkg::tmo_state_t state;
  logic [2:0] ticks;
  // Fires on the fifth character tick after the last push or read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= uart_regs_pkg::TO_IDLE;
      ticks <= 3'h0;
    end else if (!enable || !has_data || activity) begin
      state <= uart_regs_pkg::TO_IDLE;
      ticks <= 3'h0;
    end else begin
      case (state)
        uart_regs_pkg::TO_IDLE: begin
          state <= uart_regs_pkg::TO_COUNT;
        end
        uart_regs_pkg::TO_COUNT: begin
          if (char_tick && ticks == uart_regs_pkg::TIMEOUT_CHARS) begin
            state <= uart_regs_pkg::TO_FIRED;
          end else if (char_tick) begin
            ticks <= ticks + 3'h1;
          end
        end
        uart_regs_pkg::TO_FIRED: begin
          state <= uart_regs_pkg::TO_FIRED;
        end
        default: begin
          state <= uart_regs_pkg::TO_IDLE;
        end
      endcase
    end
  end
  assign timeout = state == uart_regs_pkg::TO_FIRED;
  property p_tmo_cause;
    @(posedge clk) disable iff (reset) $rose(timeout) |-> $past(char_tick) && $past(ticks) == 3'h4;
  endproperty
  a_tmo_cause: assert property (p_tmo_cause) else $error("timeout without four counted ticks");
  property p_tmo_quiet;
    @(posedge clk) disable iff (reset) activity |=> !timeout;
  endproperty
  a_tmo_quiet: assert property (p_tmo_quiet) else $error("timeout right after activity");
endmodule

/* test/serial_engine_model.sv */
`timescale 1ns/1ps
module serial_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic shift_idle,
  // Receive side
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic char_tick,
  // Control
  input wire logic stall
);
  logic [7:0] last_tx;
  assign tx_ready = !stall;
  assign shift_idle = !tx_valid;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_tx <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      last_tx <= tx_data;
    end
  end
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    char_tick = 1'b0;
  end
  // Data line shows the inverse outside a transfer
  task send(input logic [7:0] b);
    @(posedge clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      char_tick <= 1'b1;
      @(posedge clk);
      char_tick <= 1'b0;
    end
  endtask
endmodule

/* test/uart_host_regmap_irq_enable_tb_top.sv */
`timescale 1ns/1ps
module uart_host_regmap_irq_enable_tb_top;
  logic clk, reset, psel, penable, pwrite, stall, slverr, pready, pslverr;
  logic tx_valid, tx_ready, shift_idle, rx_valid, char_tick, host_irq;
  logic [7:0] paddr, tx_data, rx_data;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] divisor;
  logic [3:0] modem_lines;
  logic [6:0] line_setup;
  uart_regs_pkg::line_err_t line_err;
  uart_regs_pkg::modem_delta_t modem_delta;
  int num_errors = 0;
  int samples_checked = 0;
  int lv[4] = '{1, 4, 8, 14};
  uart_host_regmap u_uart_host_regmap (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_SHIFT_IDLE(shift_idle),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .CHAR_TICK(char_tick), .LINE_ERR(line_err),
    .MODEM_DELTA(modem_delta), .MODEM_LINES(modem_lines), .BAUD_DIVISOR(divisor), .LINE_SETUP(line_setup),
    .HOST_IRQ_OUT(host_irq));
  serial_engine_model u_serial_engine_model (.clk(clk), .reset(reset), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .shift_idle(shift_idle), .rx_data(rx_data),
    .rx_valid(rx_valid), .char_tick(char_tick), .stall(stall));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    repeat (2) @(posedge clk);
    apb(1'b0, idx, 8'h00);
    check(name, rd, exp);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Event pulse on line errors or modem deltas
  task ev(input logic m, input logic [3:0] v);
    @(posedge clk);
    if (m) modem_delta <= uart_regs_pkg::modem_delta_t'(v);
    else line_err <= uart_regs_pkg::line_err_t'(v);
    @(posedge clk);
    modem_delta <= '0;
    line_err <= '0;
  endtask
  initial begin
    #300000;
    num_errors++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    stall = 1'b0;
    line_err = '0;
    modem_delta = '0;
    modem_lines = 4'h5;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rdchk("ier_reset", 6'h01, 32'h0);
    wt(1);
    check("irq_reset", host_irq, 32'h0);
    apb(1'b1, 6'h01, 8'hff);
    rdchk("ier_upper", 6'h01, 32'h0f);
    apb(1'b1, 6'h08, 8'h0f);
    apb(1'b1, 6'h01, 8'h02);
    wt(2);
    check("irq_tx_empty", host_irq, 32'h1);
    apb(1'b1, 6'h01, 8'h00);
    wt(2);
    check("irq_all_off", host_irq, 32'h0);
    rdchk("id_all_off", 6'h02, 32'h01);
    $display("test enables done");
    apb(1'b1, 6'h03, 8'h83);
    apb(1'b1, 6'h00, 8'h34);
    apb(1'b1, 6'h01, 8'h12);
    wt(1);
    check("divisor", divisor, 32'h1234);
    check("line_setup", line_setup, 32'h03);
    rdchk("div_high", 6'h01, 32'h12);
    apb(1'b1, 6'h03, 8'h00);
    rdchk("ier_back", 6'h01, 32'h00);
    $display("test divisor done");
    stall <= 1'b1;
    apb(1'b1, 6'h00, 8'ha5);
    wt(2);
    check("tx_head", {tx_valid, tx_data}, 32'h1a5);
    stall <= 1'b0;
    wt(3);
    check("tx_taken", {tx_valid, u_serial_engine_model.last_tx}, 32'h0a5);
    u_serial_engine_model.send(8'h5a);
    apb(1'b1, 6'h08, 8'h0f);
    apb(1'b1, 6'h01, 8'h01);
    wt(2);
    check("irq_rx", host_irq, 32'h1);
    rdchk("line_rx", 6'h05, 32'h61);
    rdchk("rx_byte", 6'h00, 32'h5a);
    apb(1'b1, 6'h08, 8'h01);
    wt(2);
    check("irq_rx_gone", host_irq, 32'h0);
    $display("test data done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 6'h02, {k[1:0], 6'h03});
      wt(2);
      repeat (lv[k] - 1) u_serial_engine_model.send(8'h10);
      rdchk("id_below", 6'h02, 32'hc1);
      u_serial_engine_model.send(8'h11);
      rdchk("id_trigger", 6'h02, 32'hc4);
    end
    apb(1'b1, 6'h02, 8'hc3);
    wt(2);
    u_serial_engine_model.send(8'h22);
    u_serial_engine_model.tick(4);
    rdchk("id_no_timeout", 6'h02, 32'hc1);
    apb(1'b1, 6'h08, 8'h01);
    wt(1);
    check("irq_no_timeout", host_irq, 32'h0);
    u_serial_engine_model.tick(1);
    rdchk("id_timeout", 6'h02, 32'hcc);
    wt(1);
    check("irq_timeout", host_irq, 32'h1);
    apb(1'b1, 6'h02, 8'h00);
    $display("test fifo done");
    apb(1'b1, 6'h08, 8'h0f);
    apb(1'b1, 6'h01, 8'h04);
    ev(1'b0, 4'h1);
    wt(2);
    check("irq_line_err", host_irq, 32'h1);
    rdchk("line_err", 6'h05, 32'h62);
    apb(1'b1, 6'h01, 8'h00);
    apb(1'b1, 6'h08, 8'h0f);
    ev(1'b1, 4'h1);
    wt(2);
    check("irq_modem_off", host_irq, 32'h0);
    rdchk("modem_state", 6'h06, 32'h51);
    apb(1'b1, 6'h08, 8'h0f);
    ev(1'b1, 4'h4);
    apb(1'b1, 6'h01, 8'h08);
    wt(2);
    check("irq_modem_on", host_irq, 32'h1);
    modem_lines <= 4'ha;
    rdchk("modem_teri", 6'h06, 32'ha4);
    apb(1'b1, 6'h08, 8'h0f);
    wt(1);
    check("irq_modem_clr", host_irq, 32'h0);
    ev(1'b1, 4'h8);
    wt(2);
    check("irq_modem_dcd", host_irq, 32'h1);
    rdchk("unmapped", 6'h04, 32'h0);
    check("unmapped_err", slverr, 32'h1);
    $display("test events done");
    summarize();
  end
endmodule
